// ===== core/swd_pkg.sv
/*
  types shared by the supply watchdog block.
  assumes swd_regs.svh is on the include path.
*/
package swd_pkg;
  // comparator results, already digitised
  typedef struct packed {
    logic level_above_low;
    logic level_above_high;
    logic main_above_trip;
    logic main_above_battery;
  } swd_cmp_type;

  typedef enum logic [1:0] {SWD_RUN, SWD_FIRE, SWD_HOLD} swd_state_type;
endpackage : swd_pkg

// ===== core/swd_regs.svh
/*
  timing and reset constants for the supply watchdog and switchover block.
  assumes inclusion by bare name from the swd_sync and swd_top modules.
*/
`ifndef SWD_REGS_SVH
`define SWD_REGS_SVH
`define SWD_CLK_HZ          50000000
`define SWD_PERIOD_MS       800
`define SWD_PERIOD_CYC      ((`SWD_CLK_HZ / 1000) * `SWD_PERIOD_MS)
`define SWD_KICK_NUM        7
`define SWD_KICK_DEN        8
`define SWD_TICK_DIV        1000
`define SWD_RST_HOLD        16
`define SWD_CNT_W           32
`define SWD_LEVEL_OK_RST    1'b1
`define SWD_SEL_MAIN_RST    1'b0
`define SWD_CMP_RST         4'hF
`endif

// ===== core/swd_sync.sv
/*
  two-flop synchroniser for a bundle of comparator bits.
  assumes inputs are steady levels relative to clk.
*/
`timescale 1ns/1ps
`include "swd_regs.svh"
module swd_sync (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // bundle
  input  wire swd_pkg::swd_cmp_type din,
  output swd_pkg::swd_cmp_type     dout
);
  import swd_pkg::*;
  swd_cmp_type stage1;

  // first stage feeds only the second
  // reset to the all-good reading, else a false fail and battery pick follow reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage1 <= `SWD_CMP_RST;
      dout   <= `SWD_CMP_RST;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule : swd_sync

// ===== core/swd_top.sv
/*
  supply watchdog and switchover: level-fail output with hysteresis,
  dual-edge watchdog with internal retrigger, supply selector.
  assumes the comparator bits and activity pins are synchronous levels.
*/
// Summary of operation
// - level-fail output low once level falls below the lower threshold
// - level-fail output returns high only above threshold plus hysteresis
// - both edges of the activity input restart the watchdog timer
// - floating activity input keeps watchdog retriggered, never times out
// - internal drive holds activity low 7/8 period, then pulses high
// - battery selected only when main below trip and battery above main
// - main reselected as soon as it passes battery or trip threshold
// - reset output is active low
`timescale 1ns/1ps
`include "swd_regs.svh"
module swd_top #(
  parameter int PERIOD_CYC = `SWD_PERIOD_CYC,
  parameter int TICK_DIV   = `SWD_TICK_DIV
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // comparator results
  input  wire swd_pkg::swd_cmp_type cmp_in,
  // activity pin: input, internal drive, enable
  input  wire logic                 activity_input,
  input  wire logic                 activity_floating,
  output logic                      activity_out,
  output logic                      activity_oe,
  // outputs
  output logic                      level_fail_output,
  output logic                      select_battery,
  output logic                      reset_n
);
  import swd_pkg::*;

  localparam int PERIOD_TICKS = PERIOD_CYC / TICK_DIV;
  localparam int KICK_TICKS   = (PERIOD_TICKS * `SWD_KICK_NUM) / `SWD_KICK_DEN;

  swd_cmp_type               cmp;
  logic [`SWD_CNT_W-1:0]     div_cnt;
  logic                      tick;
  logic [`SWD_CNT_W-1:0]     wd_cnt;
  logic [`SWD_CNT_W-1:0]     hold_cnt;
  logic                      act_prev;
  logic                      act_edge;
  logic                      timeout;
  swd_state_type             state;

  // synchronise analog comparison results
  swd_sync u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (cmp_in),
    .dout    (cmp)
  );

  // hysteresis: two thresholds
  always_ff @(posedge clk) begin
    if (sys_rst)
      level_fail_output <= `SWD_LEVEL_OK_RST;
    else if (!cmp.level_above_low)
      level_fail_output <= 1'b0;
    else if (cmp.level_above_high)
      level_fail_output <= 1'b1;
  end

  // supply selector from function table
  always_ff @(posedge clk) begin
    if (sys_rst)
      select_battery <= `SWD_SEL_MAIN_RST;
    else
      select_battery <= !cmp.main_above_trip && !cmp.main_above_battery;
  end

  // free-running time base, period counted in ticks
  always_ff @(posedge clk) begin
    if (sys_rst || div_cnt == `SWD_CNT_W'(TICK_DIV - 1))
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 1'b1;
  end
  assign tick = (div_cnt == `SWD_CNT_W'(TICK_DIV - 1));

  // internal drive when the pin floats: low 7/8, then a high pulse
  assign activity_oe  = activity_floating;
  always_ff @(posedge clk) begin
    if (sys_rst)
      activity_out <= 1'b0;
    else
      activity_out <= (wd_cnt >= `SWD_CNT_W'(KICK_TICKS));
  end

  // both edges count; floating pin sees internal drive
  logic act_level;
  assign act_level = activity_floating ? activity_out : activity_input;
  always_ff @(posedge clk) begin
    if (sys_rst)
      act_prev <= 1'b0;
    else
      act_prev <= act_level;
  end
  assign act_edge = act_level ^ act_prev;

  // watchdog counter, restarted on edges and after reset hold
  always_ff @(posedge clk) begin
    if (sys_rst || act_edge || state != SWD_RUN)
      wd_cnt <= '0;
    else if (tick)
      wd_cnt <= wd_cnt + 1'b1;
  end
  assign timeout = (state == SWD_RUN) && tick &&
                   (wd_cnt == `SWD_CNT_W'(PERIOD_TICKS - 1)) && !act_edge;

  // timeout sequencing
  always_ff @(posedge clk) begin
    if (sys_rst)
      state <= SWD_RUN;
    else begin
      case (state)
        SWD_RUN:  if (timeout) state <= SWD_FIRE;
        SWD_FIRE: state <= SWD_HOLD;
        SWD_HOLD: if (hold_cnt == `SWD_CNT_W'(`SWD_RST_HOLD - 1)) state <= SWD_RUN;
        default:  state <= SWD_RUN;
      endcase
    end
  end

  // reset pulse width counter
  always_ff @(posedge clk) begin
    if (sys_rst || state == SWD_RUN)
      hold_cnt <= '0;
    else if (state == SWD_HOLD)
      hold_cnt <= hold_cnt + 1'b1;
  end

  // active-low reset output, registered
  always_ff @(posedge clk) begin
    if (sys_rst)
      reset_n <= 1'b1;
    else
      reset_n <= (state == SWD_RUN) && !timeout;
  end

  // low synchronised reading forces fail on the next cycle
  level_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    !cmp.level_above_low |=> !level_fail_output)
    else $error("level fail not asserted");
  // no rise without the high threshold
  level_rise_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(level_fail_output) |-> $past(cmp.level_above_high))
    else $error("level fail rose without hysteresis");
  // battery only when both comparisons low
  battery_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 select_battery |-> !$past(cmp.main_above_trip) && !$past(cmp.main_above_battery))
    else $error("battery selected wrongly");
  // recovery back to main in one cycle
  main_back_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cmp.main_above_trip || cmp.main_above_battery) |=> !select_battery)
    else $error("main not reselected");
  // an edge clears the counter
  edge_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
    act_edge |=> wd_cnt == '0)
    else $error("edge did not restart timer");
  // timeout drives reset low next cycle
  timeout_rst_a: assert property (@(posedge clk) disable iff (sys_rst)
    timeout |=> !reset_n ##1 !reset_n)
    else $error("timeout without reset");
  // floating input never times out
  float_safe_a: assert property (@(posedge clk) disable iff (sys_rst)
    activity_floating && $past(activity_floating) |-> !timeout)
    else $error("timeout while floating");
  // internal pulse only in last eighth
  kick_late_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(activity_out) |-> $past(wd_cnt) >= `SWD_CNT_W'(KICK_TICKS))
    else $error("internal pulse too early");

  // further checks on hysteresis, selector, reset sequencing, time base and internal drive
  // both thresholds passed restores the output
  level_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmp.level_above_low && cmp.level_above_high |=> level_fail_output)
    else $error("level fail not released");
  // a fall always follows a low reading
  level_fall_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(level_fail_output) |-> !$past(cmp.level_above_low))
    else $error("level fail fell without low reading");
  // both comparisons low picks the battery
  battery_on_a: assert property (@(posedge clk) disable iff (sys_rst)
    !cmp.main_above_trip && !cmp.main_above_battery |=> select_battery)
    else $error("battery not selected");
  // reset only ever falls because of a timeout
  rst_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(reset_n) |-> $past(timeout))
    else $error("reset fell without timeout");
  // falling reset coincides with the fire state
  rst_fire_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(reset_n) |-> state == SWD_FIRE)
    else $error("reset fell outside fire state");
  // reset held low through fire and hold
  hold_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    state != SWD_RUN |=> !reset_n)
    else $error("reset released during hold");
  // reset high while running without timeout
  run_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    state == SWD_RUN && !timeout |=> reset_n)
    else $error("reset low while running");
  // activity ignored while the reset pulse stands
  hold_ignore_a: assert property (@(posedge clk) disable iff (sys_rst)
    state != SWD_RUN |=> wd_cnt == '0)
    else $error("timer moved during reset pulse");
  // timer starts from zero when reset is released
  restart_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(reset_n) |-> $past(wd_cnt) == '0)
    else $error("timer not restarted at release");
  // time base wraps after each tick
  tick_wrap_a: assert property (@(posedge clk) disable iff (sys_rst)
    tick |=> div_cnt == '0)
    else $error("time base did not wrap");
  // internal pulse is brief when it drives the pin
  pulse_brief_a: assert property (@(posedge clk) disable iff (sys_rst)
    activity_floating && $past(activity_floating) && $rose(activity_out) |-> ##2 !activity_out)
    else $error("internal pulse too long");
  // internal drive low for the first seven eighths
  kick_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    wd_cnt < `SWD_CNT_W'(KICK_TICKS) |=> !activity_out)
    else $error("internal drive high too early");
endmodule : swd_top

// ===== verification/swd_proc_model.sv
/* processor model that kicks the watchdog pin.
   assumes the bench sets run, mode and gap between kicks. */
`timescale 1ns/1ps
module swd_proc_model (
  // clock and control
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic        toggle_mode,
  input  wire logic [15:0] gap,
  // pin drive
  output logic             pin
);
  logic [15:0] cnt = 16'h0000;
  initial pin = 1'b0;
  // kick every gap+1 cycles; pin held low when idle to save current
  always @(posedge clk) begin
    cnt <= (!run || cnt >= gap) ? 16'h0000 : cnt + 16'h0001;
    pin <= #1 !run ? 1'b0 : toggle_mode ? pin ^ (cnt >= gap) : (cnt >= gap);
  end
endmodule : swd_proc_model

// ===== verification/swd_top_tb_top.sv
/* self-checking bench for the supply watchdog block.
   assumes short period: 800 cycles, tick divider 10. */
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t mismatch", $time); end end
module swd_top_tb_top;
  import swd_pkg::*;
  logic clk, sys_rst, floating, run, tmode, pin_p, act_out, act_oe, lfo, sel, rst_n;
  logic [15:0] gap;
  logic [31:0] seed = 32'hE67C59CA;
  swd_cmp_type cmp;
  int error_cnt = 0, check_count = 0, lf_m, lo, hi, t;
  wire pin_w = act_oe ? act_out : pin_p; // internal drive wins while enabled
  swd_top #(.PERIOD_CYC(800), .TICK_DIV(10)) swd_top_inst (.clk(clk), .sys_rst(sys_rst),
    .cmp_in(cmp), .activity_input(pin_w), .activity_floating(floating),
    .activity_out(act_out), .activity_oe(act_oe), .level_fail_output(lfo),
    .select_battery(sel), .reset_n(rst_n));
  swd_proc_model swd_proc_model_inst (.clk(clk), .run(run), .toggle_mode(tmode),
    .gap(gap), .pin(pin_p));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  // count reset cycles and internal drive highs over a window
  task automatic watch(input int n);
    lo = 0;
    hi = 0;
    repeat (n) begin
      cyc(1);
      lo += (rst_n !== 1'b1);
      hi += (act_out === 1'b1);
    end
  endtask : watch
  // bounded wait for reset_n to reach a level
  task automatic wait_rst(input logic lvl, input int lim);
    t = 0;
    while (rst_n !== lvl) begin
      cyc(1);
      t++;
      if (t > lim) begin
        error_cnt++;
        $display("[ERR] %0t wait timeout", $time);
        summarize();
      end
    end
  endtask : wait_rst
  initial begin
    {sys_rst, floating, run, tmode, gap, cmp} = {1'b1, 1'b0, 1'b1, 1'b0, 16'd300, 4'hF};
    lf_m = 1;
    cyc(4);
    sys_rst = 1'b0;
    // random levels in three zones: below, in hysteresis band, above
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      cmp = {seed[1:0] != 2'b00, seed[1:0] == 2'b11, seed[5:4]};
      if (seed[1:0] == 2'b00) lf_m = 0;
      else if (seed[1:0] == 2'b11) lf_m = 1;
      cyc(4);
      `CHK(lfo, lf_m[0])
      `CHK(sel, !seed[5] && !seed[4])
    end
    // pulse kicks inside 7/8 period, then single edges of either direction
    gap = 16'd690;
    watch(2000);
    `CHK(lo, 0)
    {tmode, gap} = {1'b1, 16'd500};
    watch(2000);
    `CHK(lo, 0)
    // kicks stop: timeout, reset pulse, restart after release
    run = 1'b0;
    wait_rst(1'b0, 900);
    `CHK(t >= 290 && t <= 810, 1'b1)
    for (int k = 0; k < 2; k++) begin
      wait_rst(1'b1, 40);
      `CHK(t >= 15 && t <= 19, 1'b1)
      wait_rst(1'b0, 900);
      `CHK(t >= 780 && t <= 810, 1'b1)
    end
    // unconnected pin: internal retrigger, mostly low
    wait_rst(1'b1, 40);
    floating = 1'b1;
    watch(3000);
    `CHK(lo, 0)
    `CHK(hi > 0 && hi <= 3000 / 8, 1'b1)
    `CHK(act_oe, 1'b1)
    summarize();
  end
endmodule : swd_top_tb_top
